// [src/qdsc_ctrl.sv]
// quad dac serial command controller top
`timescale 1ns/100ps
`default_nettype none
module qdsc_ctrl (
    input  wire logic        REF_CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        SCLK_I,
    input  wire logic        FRAME_N_I,
    input  wire logic        SERIAL_DATA_IN_I,
    input  wire logic        LOAD_DAC_N_I,
    output logic             SERIAL_DATA_OUT_O,
    output logic             SERIAL_DATA_OUT_OE_O,
    output logic [39:0]      DAC_CODE_O,
    output logic [39:0]      INPUT_CODE_O,
    output logic [7:0]       PD_MODE_O,
    output logic [3:0]       OUT_VALID_O,
    output logic             CHAIN_MODE_ENABLE_O
);
    // ---------------- link domain (serial clock) ----------------
    logic [23:0] shift_q;
    logic [23:0] shift_d;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic        sdo_q;
    // link flops have no clock under reset; start them at a known level
    logic        frame_tog_q   = 1'b0;
    logic        frame_ok_q    = 1'b0;
    logic        rd_tog_seen_q = 1'b0;
    logic        rd_active_q   = 1'b0;
    logic [23:0] rd_word_s_q;

    always_comb begin
        shift_d = {shift_q[22:0], SERIAL_DATA_IN_I};
        cnt_d   = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;
    end

    // sampling on falling edge; frame low gates it, count restarts per frame
    always_ff @(negedge SCLK_I or posedge FRAME_N_I) begin
        if (FRAME_N_I) begin
            cnt_q <= 6'h00;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
        end
    end

    // frame end handed to system domain by toggle, word held stable
    // count read before its async clear takes effect at the same edge
    always_ff @(posedge FRAME_N_I) begin
        frame_tog_q <= ~frame_tog_q;
        frame_ok_q  <= cnt_q == 6'(qdsc_pkg::FRAME_BITS);
    end

    // readback toggle is long settled when the next frame opens
    logic        rd_tog_q;
    logic [23:0] rd_word_q;
    always_ff @(negedge FRAME_N_I) begin
        rd_active_q   <= rd_tog_q != rd_tog_seen_q;
        rd_tog_seen_q <= rd_tog_q;
        rd_word_s_q   <= rd_word_q;
    end

    logic [23:0] rd_shift_q;

    // output changes on rising edge, stable at next falling edge
    always_ff @(posedge SCLK_I) begin
        if (rd_active_q && cnt_q == 6'h00) begin
            sdo_q      <= rd_word_s_q[23];
            rd_shift_q <= {rd_word_s_q[22:0], 1'b0};
        end else if (rd_active_q) begin
            sdo_q      <= rd_shift_q[23];
            rd_shift_q <= {rd_shift_q[22:0], 1'b0};
        end else begin
            sdo_q      <= shift_q[23];
        end
    end

    assign SERIAL_DATA_OUT_O    = sdo_q;
    assign SERIAL_DATA_OUT_OE_O = CHAIN_MODE_ENABLE_O
                                  | (rd_active_q & ~FRAME_N_I);

    // ---------------- system domain ----------------
    logic        tog_s1_q;
    logic        tog_s2_q;
    logic        tog_s3_q;
    logic        ld_s1_q;
    logic        ld_s2_q;
    logic        ld_s3_q;
    logic [23:0] word_q;
    logic        word_ok_q;

    always_ff @(posedge REF_CLK_I) begin
        tog_s1_q <= frame_tog_q;
        tog_s2_q <= tog_s1_q;
        tog_s3_q <= tog_s2_q;
        ld_s1_q  <= LOAD_DAC_N_I;
        ld_s2_q  <= ld_s1_q;
        ld_s3_q  <= ld_s2_q;
        word_q   <= shift_q;
        word_ok_q <= frame_ok_q;
    end

    qdsc_pkg::qdsc_frame_type fr;
    assign fr = word_q;

    logic        exec;
    logic        ld_fall;
    assign exec    = tog_s2_q != tog_s3_q;
    assign ld_fall = ld_s3_q & ~ld_s2_q;

    logic [9:0]  in_q [4];
    logic [9:0]  in_d [4];
    logic [9:0]  dac_q [4];
    logic [9:0]  dac_d [4];
    logic [7:0]  pd_q;
    logic [7:0]  pd_d;
    logic [3:0]  mask_q;
    logic [3:0]  mask_d;
    logic        chain_q;
    logic        chain_d;
    qdsc_pkg::qdsc_rdbk_type rdbk_q;
    qdsc_pkg::qdsc_rdbk_type rdbk_d;
    logic        rd_tog_d;
    logic [23:0] rd_word_d;
    logic [5:0]  wake_q [4];
    logic [5:0]  wake_d [4];

    function automatic logic [1:0] rdbk_sel(input logic [3:0] a);
        logic [1:0] s;
        s = 2'h0;
        unique case (a)
            4'h2:    s = 2'h1;
            4'h4:    s = 2'h2;
            4'h8:    s = 2'h3;
            default: s = 2'h0;
        endcase
        return s;
    endfunction : rdbk_sel

    always_comb begin
        in_d      = in_q;
        dac_d     = dac_q;
        pd_d      = pd_q;
        mask_d    = mask_q;
        chain_d   = chain_q;
        rdbk_d    = rdbk_q;
        rd_tog_d  = rd_tog_q;
        rd_word_d = rd_word_q;
        // load pin fall updates unmasked channels
        for (int c = 0; c < qdsc_pkg::NUM_CH; c++) begin
            if (ld_fall && !mask_q[c]) begin
                dac_d[c] = in_q[c];
            end
        end
        // count may exceed 24 in chain mode; word is last 24 bits
        if (exec && word_ok_q || exec && chain_q) begin
            for (int c = 0; c < qdsc_pkg::NUM_CH; c++) begin
                if (fr.addr[c]) begin
                    unique case (fr.cmd)
                        qdsc_pkg::CMD_WR_IN: begin
                            in_d[c] = fr.data[15:6];
                            if (!ld_s2_q) begin
                                dac_d[c] = fr.data[15:6];
                            end
                        end
                        qdsc_pkg::CMD_UPD:    dac_d[c] = in_q[c];
                        qdsc_pkg::CMD_WR_UPD: begin
                            in_d[c]  = fr.data[15:6];
                            dac_d[c] = fr.data[15:6];
                        end
                        default: ;
                    endcase
                end
            end
            unique case (fr.cmd)
                qdsc_pkg::CMD_PWR:   pd_d    = fr.data[7:0];
                qdsc_pkg::CMD_MASK:  mask_d  = fr.data[3:0];
                qdsc_pkg::CMD_CHAIN: chain_d = fr.data[0];
                qdsc_pkg::CMD_RDBK: begin
                    rdbk_d.rdbk_ch    = rdbk_sel(fr.addr);
                    rd_word_d = {4'h0, 4'h0, dac_q[rdbk_sel(fr.addr)], 6'h00};
                    rd_tog_d  = ~rd_tog_q;
                end
                default: ;
            endcase
            rdbk_d.rdbk_armed = fr.cmd == qdsc_pkg::CMD_RDBK;
        end
        for (int c = 0; c < qdsc_pkg::NUM_CH; c++) begin
            wake_d[c] = wake_q[c];
            if (pd_d[2*c +: 2] != qdsc_pkg::PD_NORMAL) begin
                wake_d[c] = 6'(qdsc_pkg::WAKE_CYCLES);
            end else if (wake_q[c] != 6'h00) begin
                wake_d[c] = wake_q[c] - 6'h01;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            for (int c = 0; c < qdsc_pkg::NUM_CH; c++) begin
                in_q[c]   <= qdsc_pkg::CODE_RESET;
                dac_q[c]  <= qdsc_pkg::CODE_RESET;
                wake_q[c] <= 6'h00;
            end
            pd_q      <= qdsc_pkg::PD_RESET;
            mask_q    <= qdsc_pkg::MASK_RESET;
            chain_q   <= 1'b0;
            rdbk_q    <= '0;
            rd_tog_q  <= 1'b0;
            rd_word_q <= 24'h000000;
        end else begin
            in_q      <= in_d;
            dac_q     <= dac_d;
            wake_q    <= wake_d;
            pd_q      <= pd_d;
            mask_q    <= mask_d;
            chain_q   <= chain_d;
            rdbk_q    <= rdbk_d;
            rd_tog_q  <= rd_tog_d;
            rd_word_q <= rd_word_d;
        end
    end

    always_comb begin
        for (int c = 0; c < qdsc_pkg::NUM_CH; c++) begin
            DAC_CODE_O[10*c +: 10]   = dac_q[c];
            INPUT_CODE_O[10*c +: 10] = in_q[c];
            OUT_VALID_O[c] = pd_q[2*c +: 2] == qdsc_pkg::PD_NORMAL
                             && wake_q[c] == 6'h00;
        end
    end
    assign PD_MODE_O           = pd_q;
    assign CHAIN_MODE_ENABLE_O = chain_q;

    a_chain_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        exec && word_ok_q && fr.cmd == qdsc_pkg::CMD_CHAIN
        |=> chain_q == $past(fr.data[0]))
        else $error("chain mode not written");
    a_mask_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        exec && word_ok_q && fr.cmd == qdsc_pkg::CMD_MASK
        |=> mask_q == $past(fr.data[3:0]))
        else $error("load mask not written");
    a_pd_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        exec && word_ok_q && fr.cmd == qdsc_pkg::CMD_PWR
        |=> pd_q == $past(fr.data[7:0]))
        else $error("power-down bits not written");
    a_direct_update: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        exec && word_ok_q && fr.cmd == qdsc_pkg::CMD_WR_UPD && fr.addr[0]
        |=> dac_q[0] == $past(fr.data[15:6]))
        else $error("direct update missed");
    a_update_copy: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        exec && word_ok_q && fr.cmd == qdsc_pkg::CMD_UPD && fr.addr[1]
        |=> dac_q[1] == $past(in_q[1]) && $stable(in_q[1]))
        else $error("update copy wrong");
    a_load_fall: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        ld_fall && !mask_q[2] && !exec
        |=> dac_q[2] == $past(in_q[2]))
        else $error("load fall did not copy");
    a_masked_hold: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        ld_fall && mask_q[3] && !exec |=> $stable(dac_q[3]))
        else $error("masked channel updated");
    a_wake_delay: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        $fell(pd_q[3] | pd_q[2]) |-> !OUT_VALID_O[1] [*8])
        else $error("output valid too soon");
    c_chain_on: cover property (@(posedge REF_CLK_I) $rose(chain_q));
    c_load_fall: cover property (@(posedge REF_CLK_I) ld_fall);
    c_readback: cover property (@(posedge REF_CLK_I) $changed(rd_tog_q));
endmodule : qdsc_ctrl
`default_nettype wire

// [src/qdsc_pkg.sv]
// package for the quad dac serial command controller
// Overview of operation
// - command 0011 writes input and dac registers of addressed channels immediately
// - command 1000 sets chain mode from DB0; standalone after reset
// - in chain mode clocks beyond the 24th shift oldest bit out
// - serial data out changes on rising serial clock edge
// - frame select rise latches and executes word; later clocks ignored
// - command 1001 arms readback of the channel named by one address bit
// - readback with zero or several address bits reads channel A
// - next frame shifts out selected register; top eight bits zero
// - readback enables serial output for one frame even outside chain mode
// - command 0100 sets two power-down bits per channel from DB7..DB0
// - power-down pair decodes to normal, 1k, 100k or three-state
// - dac registers keep contents and accept updates while powered down
// - leaving power-down takes about 4.5 us before output valid
// - each channel has an input register and a dac register
// - load pin low during 0001 write updates input and dac registers
// - load pin high: input only; later load fall copies to dac
// - command 0010 copies addressed input registers into dac registers
// - each load pin fall copies inputs to dacs of unmasked channels
// - load pin held low ignores load mask bits
// - frame is 24 bits msb first: command, address D..A, data
// - serial input sampled on falling serial clock while frame select low
// - each address bit selects one channel, any combination allowed
// - command 0101 loads four bit load mask from DB3..DB0
package qdsc_pkg;
    localparam int          FRAME_BITS   = 24;
    localparam int          NUM_CH       = 4;
    localparam int          CODE_BITS    = 10;
    localparam logic [3:0]  CMD_NOP      = 4'h0;
    localparam logic [3:0]  CMD_WR_IN    = 4'h1;
    localparam logic [3:0]  CMD_UPD      = 4'h2;
    localparam logic [3:0]  CMD_WR_UPD   = 4'h3;
    localparam logic [3:0]  CMD_PWR      = 4'h4;
    localparam logic [3:0]  CMD_MASK     = 4'h5;
    localparam logic [3:0]  CMD_CHAIN    = 4'h8;
    localparam logic [3:0]  CMD_RDBK     = 4'h9;
    localparam int          CMD_MSB      = 23;
    localparam int          ADDR_MSB     = 19;
    localparam int          CODE_MSB     = 15;
    localparam logic [7:0]  PD_RESET     = 8'h00;
    localparam logic [3:0]  MASK_RESET   = 4'h0;
    localparam logic [9:0]  CODE_RESET   = 10'h000;
    localparam int          WAKE_NS      = 4500;
    localparam int          CLK_NS       = 100;
    localparam int          WAKE_CYCLES  = WAKE_NS / CLK_NS;
    localparam logic [1:0]  PD_NORMAL    = 2'h0;
    localparam logic [1:0]  PD_1K        = 2'h1;
    localparam logic [1:0]  PD_100K      = 2'h2;
    localparam logic [1:0]  PD_TRISTATE  = 2'h3;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [15:0] data;
    } qdsc_frame_type;

    typedef struct packed {
        logic                          rdbk_armed;
        logic [1:0]                    rdbk_ch;
    } qdsc_rdbk_type;
endpackage : qdsc_pkg

// [tb/qdsc_host.sv]
// spi host model that drives the controller link
`timescale 1ns/100ps
`default_nettype none
module qdsc_host (
    input  wire logic ref_clk_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      sclk_o,
    output logic      frame_n_o,
    output logic      serial_data_in_o
);
    logic [47:0] cap;
    logic        oe_all;

    initial begin
        sclk_o    = 1'b0;
        frame_n_o = 1'b1;
        serial_data_in_o    = 1'b0;
    end

    // n is 24 per chained device; other counts only to be refused
    task automatic send(input logic [47:0] w, input int n);
        cap    = '0;
        oe_all = 1'b1;
        @(posedge ref_clk_i);
        #1 frame_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in_o = w[i];
            #4 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
            cap    = {cap[46:0], sdo_i};
            oe_all = oe_all & sdo_oe_i;
            #3.5;
        end
        frame_n_o = 1'b1;
        serial_data_in_o    = ~serial_data_in_o;
        repeat (12) @(posedge ref_clk_i);
    endtask : send
endmodule : qdsc_host
`default_nettype wire

// [tb/tb_qdsc_ctrl.sv]
// self-checking bench for the quad dac serial command controller
`timescale 1ns/100ps
`default_nettype none
module tb_qdsc_ctrl;
    logic        ref_clk, rst_n, sclk, frame_n, serial_data_in, load_n;
    logic        serial_data_out, sdo_oe, chain;
    logic [39:0] dac, inp;
    logic [7:0]  pd;
    logic [3:0]  vld;
    int          bad_count, n_compared;
    logic [3:0]  ra [4] = '{4'h2, 4'h0, 4'h6, 4'h8};
    logic [9:0]  re [4] = '{10'h011, 10'h3ff, 10'h3ff, 10'h201};

    always #50 ref_clk = ~ref_clk;

    qdsc_ctrl qdsc_ctrl_i (
        .REF_CLK_I           (ref_clk),
        .RSTN_I              (rst_n),
        .SCLK_I              (sclk),
        .FRAME_N_I           (frame_n),
        .SERIAL_DATA_IN_I    (serial_data_in),
        .LOAD_DAC_N_I        (load_n),
        .SERIAL_DATA_OUT_O   (serial_data_out),
        .SERIAL_DATA_OUT_OE_O(sdo_oe),
        .DAC_CODE_O          (dac),
        .INPUT_CODE_O        (inp),
        .PD_MODE_O           (pd),
        .OUT_VALID_O         (vld),
        .CHAIN_MODE_ENABLE_O (chain)
    );

    qdsc_host qdsc_host_i (
        .ref_clk_i(ref_clk),
        .sdo_i    (serial_data_out),
        .sdo_oe_i (sdo_oe),
        .sclk_o   (sclk),
        .frame_n_o(frame_n),
        .serial_data_in_o   (serial_data_in)
    );

    task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [3:0] c, input logic [3:0] a,
                      input logic [15:0] d);
        qdsc_host_i.send({24'h0, c, a, d}, 24);
    endtask : wr

    task automatic wc(input logic [3:0] c, input logic [3:0] a,
                      input logic [9:0] code);
        wr(c, a, {code, 6'h0});
    endtask : wc

    // load pin pulse while frame select is high
    task automatic ldp();
        @(posedge ref_clk);
        #1 load_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 load_n = 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : ldp

    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        ref_clk    = 1'b0;
        rst_n      = 1'b0;
        load_n     = 1'b1;
        bad_count  = 0;
        n_compared = 0;
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        wr(4'h0, 4'h0, 16'h0);
        chk(40'({chain, sdo_oe, vld, pd}), 40'h0f00, "reset");
        chk(dac, 40'h0, "dac reset");
        wc(4'h3, 4'h5, 10'h3ff);
        chk(dac, {10'h0, 10'h3ff, 10'h0, 10'h3ff}, "wr upd");
        wc(4'h1, 4'h2, 10'h155);
        chk(inp, {10'h0, 10'h3ff, 10'h155, 10'h3ff}, "in");
        chk(dac, {10'h0, 10'h3ff, 10'h0, 10'h3ff}, "dac held");
        ldp();
        chk(dac, {10'h0, 10'h3ff, 10'h155, 10'h3ff}, "ld");
        wr(4'h5, 4'h0, 16'h0002);
        wc(4'h1, 4'h2, 10'h0aa);
        ldp();
        chk(dac, {10'h0, 10'h3ff, 10'h155, 10'h3ff}, "mask");
        wc(4'h2, 4'h2, 10'h0);
        chk(dac, {10'h0, 10'h3ff, 10'h0aa, 10'h3ff}, "upd");
        chk(inp, {10'h0, 10'h3ff, 10'h0aa, 10'h3ff}, "upd in");
        wr(4'h5, 4'h0, 16'h0);
        @(posedge ref_clk);
        #1 load_n = 1'b0;
        wc(4'h1, 4'h8, 10'h201);
        chk(dac, {10'h201, 10'h3ff, 10'h0aa, 10'h3ff}, "ld low");
        #1 load_n = 1'b1;
        wr(4'h4, 4'hf, 16'h00e4);
        chk(40'(pd), 40'he4, "pd");
        chk(40'(vld), 40'h1, "pd vld");
        wc(4'h3, 4'h2, 10'h011);
        chk(dac, {10'h201, 10'h3ff, 10'h011, 10'h3ff}, "pd upd");
        wr(4'h4, 4'h0, 16'h0);
        chk(40'(vld), 40'h1, "waking");
        repeat (45) @(posedge ref_clk);
        chk(40'(vld), 40'hf, "awake");
        for (int k = 0; k < 4; k++) begin
            wr(4'h9, ra[k], 16'h0);
            wr(4'h0, 4'h0, 16'h0);
            chk(40'(qdsc_host_i.cap[15:6]), 40'(re[k]), "rb");
            chk(40'(qdsc_host_i.oe_all), 40'h1, "rb oe");
        end
        chk(40'(sdo_oe), 40'h0, "oe off");
        wr(4'h9, 4'h1, 16'h0);
        wc(4'h3, 4'h1, 10'h077);
        chk(40'(qdsc_host_i.cap[15:6]), 40'h3ff, "rb exec");
        chk(dac, {10'h201, 10'h3ff, 10'h011, 10'h077}, "rb exec");
        qdsc_host_i.send({24'h0, 4'h3, 4'h1, 16'h0}, 23);
        chk(dac, {10'h201, 10'h3ff, 10'h011, 10'h077}, "short");
        wr(4'h8, 4'h0, 16'h0001);
        chk(40'({chain, sdo_oe}), 40'h3, "chain");
        qdsc_host_i.send(48'h3148c0_383c00, 48);
        chk(40'(qdsc_host_i.cap[23:0]), 40'h3148c0, "ripple");
        chk(dac, {10'h0f0, 10'h3ff, 10'h011, 10'h077}, "latch");
        wr(4'h9, 4'h4, 16'h0);
        qdsc_host_i.send(48'hf00000, 24);
        chk(40'(qdsc_host_i.cap[15:6]), 40'h3ff, "chain rb");
        wr(4'h8, 4'h0, 16'h0);
        chk(40'({chain, sdo_oe}), 40'h0, "standalone");
        tally_and_finish();
    end
endmodule : tb_qdsc_ctrl
`default_nettype wire
